/* File: hdl/backplane.sv */
// Expansion backplane: slot select decode, interrupt mask and status, clock fan-out,
// coprocessor routing and system reset. Host and slot pins come from outside the
// core clock domain and are synchronised before use.
`timescale 1ns/10ps
module backplane import slot_pkg::*; #(
   parameter int unsigned RESET_HOLD = RESET_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire host_bus_s host_bus,
   input wire logic irq_mask_status_select_n,
   input wire logic [7:0] buffered_data_in,
   output logic [7:0] buffered_data_out,
   output logic buffered_data_oe,
   input wire logic [NUM_SLOTS-1:0] card_normal_irq_n,
   output logic card_normal_irq_n_host,
   input wire slot_clocks_s clocks_in,
   output slot_clocks_s [NUM_SLOTS-1:0] slot_clocks,
   output logic [NUM_SLOTS-1:0] slot_simple_card_select_n,
   output logic [NUM_SLOTS-1:0] slot_memctl_card_select_n,
   output logic [NUM_SLOTS-1:0] external_card_select_n,
   input wire logic [31:0] copro_data_in,
   output logic [31:0] copro_slot_data,
   output logic [NUM_SLOTS-1:0] copro_slot_enable,
   input wire logic sys_reset_n_in,
   output logic sys_reset_n_out,
   output logic sys_reset_n_oe
);
   localparam int SYNC_W = $bits(host_bus_s) + 1 + 8 + NUM_SLOTS + $bits(slot_clocks_s) + 1;

   logic [SYNC_W-1:0] sync1_r, sync2_r;
   host_bus_s bus_s;
   logic sel_s, rst_req_s;
   logic [7:0] data_s;
   logic [NUM_SLOTS-1:0] irq_s;
   slot_clocks_s clk_s;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_r <= '1;
         sync2_r <= '1;
      end else begin
         sync1_r <= {host_bus, irq_mask_status_select_n, buffered_data_in,
                     card_normal_irq_n, clocks_in, sys_reset_n_in};
         sync2_r <= sync1_r;
      end
   end
   assign {bus_s, sel_s, data_s, irq_s, clk_s, rst_req_s} = sync2_r;

   logic [1:0] slot_idx;
   logic [NUM_SLOTS-1:0] simple_nxt, memctl_nxt, ext_nxt, simple_r, memctl_r, ext_r;
   assign slot_idx = bus_s.latched_address[SLOT_ADDR_HI:SLOT_ADDR_LO];

   // Identity reads ride the slot selects.
   always_comb begin
      simple_nxt = '1;
      memctl_nxt = '1;
      ext_nxt = '1;
      simple_nxt[slot_idx] = bus_s.master_simple_card_select_n;
      memctl_nxt[slot_idx] = bus_s.master_memctl_card_select_n;
      ext_nxt[slot_idx] = bus_s.external_card_select_n;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         simple_r <= '1;
         memctl_r <= '1;
         ext_r <= '1;
      end else begin
         simple_r <= simple_nxt;
         memctl_r <= memctl_nxt;
         ext_r <= ext_nxt;
      end
   end
   assign slot_simple_card_select_n = simple_r;
   assign slot_memctl_card_select_n = memctl_r;
   assign external_card_select_n = ext_r;

   logic [IRQ_MASK_BITS-1:0] mask_r, mask_nxt;
   logic [IRQ_MASK_BITS-1:0] status;
   logic wr_sel, rd_sel, wr_prev_r, wr_prev_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic oe_r, oe_nxt;
   logic irq_r, irq_nxt;

   assign wr_sel = !sel_s && !bus_s.write_strobe_n;
   assign rd_sel = !sel_s && !bus_s.read_strobe_n;
   assign status = mask_r & ~irq_s;

   always_comb begin
      mask_nxt = mask_r;
      wr_prev_nxt = wr_sel;
      if (wr_sel && !wr_prev_r) begin
         mask_nxt = data_s[IRQ_MASK_BITS-1:0];
      end
      rd_nxt = RSVD_READ | {4'h0, status};
      oe_nxt = rd_sel;
      irq_nxt = (status == '0);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mask_r <= IRQ_MASK_RESET;
         wr_prev_r <= 1'b0;
         rd_r <= 8'h00;
         oe_r <= 1'b0;
         irq_r <= 1'b1;
      end else begin
         mask_r <= mask_nxt;
         wr_prev_r <= wr_prev_nxt;
         rd_r <= rd_nxt;
         oe_r <= oe_nxt;
         irq_r <= irq_nxt;
      end
   end
   assign buffered_data_out = rd_r;
   assign buffered_data_oe = oe_r;
   assign card_normal_irq_n_host = irq_r;

   slot_clocks_s [NUM_SLOTS-1:0] clk_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         clk_r <= '0;
      end else begin
         clk_r <= {NUM_SLOTS{clk_s}};
      end
   end
   assign slot_clocks = clk_r;

   // Coprocessor signals only on slot 2.
   logic [31:0] copro_s1_r, copro_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         copro_s1_r <= 32'h0;
         copro_r <= 32'h0;
      end else begin
         copro_s1_r <= copro_data_in;
         copro_r <= copro_s1_r;
      end
   end
   assign copro_slot_data = copro_r;
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : g_copro
         assign copro_slot_enable[g] = (g == COPRO_SLOT);
      end
   endgenerate

   logic hold_n;
   reset_stretch #(.HOLD_CYCLES(RESET_HOLD)) u_rst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .req_n(rst_req_s),
      .hold_n(hold_n)
   );
   assign sys_reset_n_out = 1'b0;
   assign sys_reset_n_oe = !hold_n;

   property p_slot_decode;
      @(posedge core_clk) disable iff (!rst_n)
      !bus_s.master_simple_card_select_n |=> !slot_simple_card_select_n[$past(slot_idx)];
   endproperty
   a_slot_decode: assert property (p_slot_decode)
      else $error("addressed slot not selected");

   property p_memctl_decode;
      @(posedge core_clk) disable iff (!rst_n)
      !bus_s.master_memctl_card_select_n |=> !slot_memctl_card_select_n[$past(slot_idx)];
   endproperty
   a_memctl_decode: assert property (p_memctl_decode)
      else $error("addressed slot memctl select missing");

   property p_one_hot;
      @(posedge core_clk) disable iff (!rst_n)
      $countones(~slot_memctl_card_select_n) <= 1;
   endproperty
   a_one_hot: assert property (p_one_hot)
      else $error("multiple memctl selects");

   property p_copro;
      @(posedge core_clk) disable iff (!rst_n)
      copro_slot_enable == 4'h4;
   endproperty
   a_copro: assert property (p_copro)
      else $error("coprocessor routed wrongly");

   property p_status;
      @(posedge core_clk) disable iff (!rst_n)
      buffered_data_oe |-> buffered_data_out[3:0] == $past(mask_r & ~irq_s);
   endproperty
   a_status: assert property (p_status)
      else $error("status mismatch");

   property p_mask;
      @(posedge core_clk) disable iff (!rst_n)
      (wr_sel && !wr_prev_r) |=> mask_r == $past(data_s[3:0]);
   endproperty
   a_mask: assert property (p_mask)
      else $error("mask not written");

   property p_rsvd;
      @(posedge core_clk) disable iff (!rst_n)
      buffered_data_out[7:4] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits nonzero");

   // The first edge after reset sees the synchroniser's reset value, so it is skipped.
   property p_clk;
      @(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> slot_clocks == {NUM_SLOTS{$past(clk_s)}};
   endproperty
   a_clk: assert property (p_clk)
      else $error("slot clock not forwarded");

   property p_reset;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(rst_req_s) |=> sys_reset_n_oe [*8];
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset pulse too short");

   property p_reset_hold;
      @(posedge core_clk) disable iff (!rst_n)
      !rst_req_s |=> sys_reset_n_oe;
   endproperty
   a_reset_hold: assert property (p_reset_hold)
      else $error("reset request not passed on");

   c_sel: cover property (@(posedge core_clk) !slot_simple_card_select_n[3]);
   c_irq: cover property (@(posedge core_clk) !card_normal_irq_n_host);
   c_rd: cover property (@(posedge core_clk) buffered_data_oe);
   c_stretch: cover property (@(posedge core_clk) $fell(sys_reset_n_oe));
endmodule // backplane

/* File: hdl/reset_stretch.sv */
// Reset pulse stretcher for the open-collector system reset line.
// Assumes req_n is already synchronised to core_clk.
`timescale 1ns/10ps
module reset_stretch import slot_pkg::*; #(
   parameter int unsigned HOLD_CYCLES = RESET_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req_n,
   output logic hold_n
);
   logic [RESET_CNT_W-1:0] cnt_r, cnt_nxt;

   // A request reloads the counter so the line is held low for the full time.
   always_comb begin
      cnt_nxt = cnt_r;
      if (!req_n) begin
         cnt_nxt = RESET_CNT_W'(HOLD_CYCLES);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_r <= RESET_CNT_W'(HOLD_CYCLES);
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign hold_n = (cnt_r == '0);
endmodule // reset_stretch

/* File: shared/slot_pkg.sv */
// Shared constants and carrier types for the expansion backplane logic.
// Assumes a single 100 MHz core clock domain.
package slot_pkg;
   localparam int NUM_SLOTS = 4;
   localparam int COPRO_SLOT = 2;
   localparam int SLOT_ADDR_HI = 15;
   localparam int SLOT_ADDR_LO = 14;
   localparam int IRQ_MASK_BITS = 4;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [7:0] RSVD_READ = 8'h00;
   localparam int CLK_MHZ = 100;
   localparam int RESET_MS = 50;
   localparam int RESET_CYCLES = RESET_MS * CLK_MHZ * 1000;
   localparam int RESET_CNT_W = 23;

   typedef struct packed {
      logic [15:0] latched_address;
      logic master_simple_card_select_n;
      logic master_memctl_card_select_n;
      logic external_card_select_n;
      logic read_strobe_n;
      logic write_strobe_n;
   } host_bus_s;

   typedef struct packed {
      logic sync_clock_2m;
      logic sync_clock_8m;
      logic reference_clock_8m;
   } slot_clocks_s;
endpackage

/* File: verif/card_slots.sv */
// Model of three expansion cards standing on the four backplane slots.
// Assumes the bench sets irq_req and the host strobes; selects come from the backplane.
`timescale 1ns/10ps
module card_slots import slot_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [NUM_SLOTS-1:0] irq_req,
   input wire logic [NUM_SLOTS-1:0] slot_sel_n,
   input wire logic read_strobe_n,
   input wire logic [3:0] offset,
   output logic [NUM_SLOTS-1:0] card_normal_irq_n,
   output logic [7:0] id_data
);
   // Slots 0 and 2 hold simple cards, slot 1 an extended-identity card, slot 3 is empty.
   localparam logic [NUM_SLOTS-1:0] FITTED = 4'h7;
   localparam logic [NUM_SLOTS-1:0][3:0] CARD_ID = {4'h0, 4'h5, 4'h0, 4'h3};
   // Bytes 2 to 7 are arbitrary identity values made up for this model.
   localparam logic [7:0][7:0] EXT_ID = {8'h44, 8'h33, 8'h22, 8'h11, 8'hC3, 8'h5A, 8'h00, 8'h00};

   always @(posedge core_clk) begin
      if (!rst_n) begin
         card_normal_irq_n <= '1;
      end else begin
         card_normal_irq_n <= ~(irq_req & FITTED);
      end
   end

   always_comb begin
      // Pull-up on bit 1; the other lines are taken as pulled low.
      id_data = 8'h02;
      for (int k = 0; k < NUM_SLOTS; k++) begin
         if (!slot_sel_n[k] && !read_strobe_n && FITTED[k]) begin
            if (offset == 4'h0) begin
               // Low byte: ID, present low, IRQ status.
               id_data = {1'b0, CARD_ID[k], 2'b00, irq_req[k]};
            end else if (CARD_ID[k] == 4'h0 && offset < 4'h8) begin
               // Eight extended bytes, width code 00.
               id_data = EXT_ID[offset[2:0]];
            end else begin
               id_data = 8'h00;
            end
         end
      end
   end
endmodule // card_slots

/* File: verif/tb_backplane.sv */
// Self-checking bench for the backplane decode, mask, clock and routing logic.
// Runs the design with a short reset stretch so that its release can be seen.
`timescale 1ns/10ps
module tb_backplane;
   import slot_pkg::*;
   logic core_clk, rst_n, sel_n, d_oe, irq_host, rs_out, rs_oe;
   host_bus_s hb;
   slot_clocks_s ck, hist [0:4];
   slot_clocks_s [NUM_SLOTS-1:0] sck;
   logic [7:0] d_in, d_out;
   logic [3:0] irq_req, irq_n, s_n, m_n, e_n, cp_en;
   logic [31:0] cp_in, cp_out;
   logic rs_req_n;
   logic [7:0] id_d;
   localparam int unsigned SIM_HOLD = 20;
   int err_total, compares, cyc;
   bit ck_on;
   typedef struct packed {logic [1:0] a; logic s; logic m; logic [3:0] es; logic [3:0] em;} row_s;
   row_s rows [7] = '{
      {2'h0, 2'h1, 4'hE, 4'hF}, {2'h1, 2'h2, 4'hF, 4'hD}, {2'h2, 2'h1, 4'hB, 4'hF},
      {2'h3, 2'h2, 4'hF, 4'h7}, {2'h3, 2'h1, 4'h7, 4'hF}, {2'h0, 2'h2, 4'hF, 4'hE},
      {2'h2, 2'h3, 4'hF, 4'hF}};
   backplane #(.RESET_HOLD(SIM_HOLD)) dut (.core_clk(core_clk), .rst_n(rst_n), .host_bus(hb),
      .irq_mask_status_select_n(sel_n), .buffered_data_in(d_in), .buffered_data_out(d_out),
      .buffered_data_oe(d_oe), .card_normal_irq_n(irq_n), .card_normal_irq_n_host(irq_host),
      .clocks_in(ck), .slot_clocks(sck), .slot_simple_card_select_n(s_n),
      .slot_memctl_card_select_n(m_n), .external_card_select_n(e_n), .copro_data_in(cp_in),
      .copro_slot_data(cp_out), .copro_slot_enable(cp_en), .sys_reset_n_in(rs_req_n),
      .sys_reset_n_out(rs_out), .sys_reset_n_oe(rs_oe));
   card_slots cards (.core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req), .slot_sel_n(s_n),
      .read_strobe_n(hb.read_strobe_n), .offset(hb.latched_address[3:0]),
      .card_normal_irq_n(irq_n), .id_data(id_d));
   task automatic chk_vec(string nm, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic waitn(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic read_status(logic [3:0] exp, logic exp_host);
      sel_n = 1'b0;
      hb.read_strobe_n = 1'b0;
      waitn(4);
      chk_vec("data_oe", 1, d_oe);
      chk_vec("status", exp, d_out[3:0]);
      chk_vec("irq_host", exp_host, irq_host);
      sel_n = 1'b1;
      hb.read_strobe_n = 1'b1;
      waitn(4);
   endtask
   task automatic write_mask(logic [7:0] v);
      sel_n = 1'b0;
      d_in = v;
      hb.write_strobe_n = 1'b0;
      waitn(4);
      hb.write_strobe_n = 1'b1;
      waitn(4);
      sel_n = 1'b1;
      waitn(2);
   endtask
   task automatic read_id(logic [1:0] slot, logic [3:0] off, logic [7:0] exp);
      hb.latched_address = {slot, 10'h000, off};
      hb.master_simple_card_select_n = 1'b0;
      hb.read_strobe_n = 1'b0;
      waitn(4);
      chk_vec("identity", exp, id_d);
      hb.master_simple_card_select_n = 1'b1;
      hb.read_strobe_n = 1'b1;
      waitn(4);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      ck = '0;
      #1.25;
      forever #62.5 ck.sync_clock_8m = ~ck.sync_clock_8m;
   end
   initial begin
      #1.25;
      forever #250 begin
         ck.sync_clock_2m = ~ck.sync_clock_2m;
         ck.reference_clock_8m = ~ck.reference_clock_8m;
      end
   end
   always @(posedge core_clk) begin
      hist[0] <= ck;
      for (int i = 1; i < 5; i++) hist[i] <= hist[i-1];
      cyc <= cyc + 1;
      if (cyc >= 4000) begin
         err_total++;
         report_and_stop();
      end
   end
   always @(negedge core_clk) begin
      if (ck_on && hist[0] == ck && hist[1] == ck && hist[2] == ck
          && hist[3] == ck && hist[4] == ck)
         for (int i = 0; i < NUM_SLOTS; i++) chk_vec("slot_clock", ck, sck[i]);
   end
   initial begin
      rst_n = 1'b0;
      rs_req_n = 1'b1;
      hb = '1;
      sel_n = 1'b1;
      d_in = 8'h00;
      irq_req = 4'h0;
      cp_in = 32'h0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      waitn(4);
      ck_on = 1'b1;
      chk_vec("simple_sel", 4'hF, s_n);
      chk_vec("irq_host", 1, irq_host);
      chk_vec("reset_oe", 1, rs_oe);
      chk_vec("reset_out", 0, rs_out);
      chk_vec("copro_en", 4'h4, cp_en);
      foreach (rows[i]) begin
         hb.latched_address = {rows[i].a, 14'h2A5C};
         {hb.master_simple_card_select_n, hb.master_memctl_card_select_n} = {rows[i].s, rows[i].m};
         waitn(4);
         chk_vec("simple_sel", rows[i].es, s_n);
         chk_vec("memctl_sel", rows[i].em, m_n);
      end
      hb.latched_address = 16'h4000;
      hb.external_card_select_n = 1'b0;
      waitn(4);
      chk_vec("ext_sel", 4'hD, e_n);
      hb = '1;
      cp_in = 32'hA5C3_1E0F;
      irq_req = 4'h3;
      waitn(4);
      chk_vec("copro_data", 32'hA5C3_1E0F, cp_out);
      read_status(4'h0, 1'b1);
      write_mask(8'hF5);
      read_status(4'h1, 1'b0);
      irq_req = 4'hC;
      waitn(4);
      read_status(4'h4, 1'b0);
      write_mask(8'hF0);
      read_status(4'h0, 1'b1);
      waitn(300);
      chk_vec("reset_oe", 0, rs_oe);
      rs_req_n = 1'b0;
      waitn(1);
      rs_req_n = 1'b1;
      waitn(10);
      chk_vec("reset_oe", 1, rs_oe);
      waitn(15);
      chk_vec("reset_oe", 0, rs_oe);
      irq_req = 4'h1;
      read_id(2'h0, 4'h0, 8'h19);
      read_id(2'h2, 4'h0, 8'h28);
      read_id(2'h1, 4'h0, 8'h00);
      read_id(2'h1, 4'h1, 8'h00);
      read_id(2'h1, 4'h7, 8'h44);
      read_id(2'h3, 4'h0, 8'h02);
      write_mask(8'h0F);
      ck_on = 1'b0;
      rst_n = 1'b0;
      waitn(3);
      rst_n = 1'b1;
      waitn(4);
      chk_vec("simple_sel", 4'hF, s_n);
      chk_vec("reset_oe", 1, rs_oe);
      read_status(4'h0, 1'b1);
      ck_on = 1'b1;
      waitn(20);
      report_and_stop();
   end
endmodule // tb_backplane
